// *** rtl/tec_top.sv ***
// trigger to exposure window control with apb register access
`default_nettype none
module tec_top import tec_pkg::*; #(
   parameter int EXP_W = 24,
   parameter int DBN_W = 16
) (
   input  wire logic              SYS_CLK,
   input  wire logic              RST_B,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              TRIG_IN,
   input  wire logic              READOUT_DONE,
   output logic                   EXPOSE,
   output logic                   READOUT_START,
   output logic                   FRAME_WAIT
);
   // ---------------------------------------------------------------
   // registers and state
   // ---------------------------------------------------------------
   logic [3:0]       ctrl_r,  ctrl_nxt;
   logic [EXP_W-1:0] expt_r,  expt_nxt;
   logic [DBN_W-1:0] dbnc_r,  dbnc_nxt;
   logic             swt_r,   swt_nxt;
   logic [31:0]      rdat_r,  rdat_nxt;
   logic             rdy_r,   rdy_nxt;
   logic             err_r,   err_nxt;
   logic             trig_s1_r, trig_s2_r;
   logic             line_act, dbn_out, dbn_prev_r;
   tec_state_e       st_r,    st_nxt;
   logic [EXP_W-1:0] cnt_r,   cnt_nxt;
   logic [5:0]       pre_r,   pre_nxt;
   logic             rd_r,    rd_nxt;
   logic             rdst_r,  rdst_nxt;
   logic             exp_r,   fw_r;
   tec_mode_e        mode;
   logic             pol_neg, enable, rise, fall, tick, edge_ok;

   function automatic logic is_map(input logic [ADDR_W-1:0] a);
      return a == ADR_CTRL || a == ADR_EXPT || a == ADR_DBNC ||
             a == ADR_SWTRG || a == ADR_STAT;
   endfunction : is_map

   // ---------------------------------------------------------------
   // apb slave: one wait state, answer registered
   // ---------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      expt_nxt = expt_r;
      dbnc_nxt = dbnc_r;
      swt_nxt  = 1'b0;
      rdat_nxt = rdat_r;
      err_nxt  = err_r;
      rdy_nxt  = PSEL && PENABLE && !rdy_r;
      if (rdy_nxt) begin
         err_nxt  = !is_map(PADDR);
         rdat_nxt = '0;
         if (!PWRITE) begin
            case (PADDR)
               ADR_CTRL:  rdat_nxt[3:0] = ctrl_r;
               ADR_EXPT:  rdat_nxt[EXP_W-1:0] = expt_r;
               ADR_DBNC:  rdat_nxt[DBN_W-1:0] = dbnc_r;
               ADR_STAT: begin
                  rdat_nxt[STAT_EXP_BIT]  = exp_r;
                  rdat_nxt[STAT_RD_BIT]   = rd_r;
                  rdat_nxt[STAT_FW_BIT]   = fw_r;
                  rdat_nxt[STAT_LINE_BIT] = dbn_out;
               end
               default:   rdat_nxt = '0;
            endcase
         end
      end
      // writes land on the edge that samples pready high
      if (PSEL && PENABLE && rdy_r && PWRITE) begin
         case (PADDR)
            ADR_CTRL:  ctrl_nxt = PWDATA[3:0];
            ADR_EXPT:  expt_nxt = PWDATA[EXP_W-1:0];
            ADR_DBNC:  dbnc_nxt = PWDATA[DBN_W-1:0];
            ADR_SWTRG: swt_nxt  = PWDATA[SWTRG_BIT];
            default:   swt_nxt  = 1'b0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         ctrl_r <= CTRL_RST;
         expt_r <= EXPT_RST;
         dbnc_r <= DBNC_RST;
         swt_r  <= 1'b0;
         rdat_r <= '0;
         rdy_r  <= 1'b0;
         err_r  <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         expt_r <= expt_nxt;
         dbnc_r <= dbnc_nxt;
         swt_r  <= swt_nxt;
         rdat_r <= rdat_nxt;
         rdy_r  <= rdy_nxt;
         err_r  <= err_nxt;
      end
   end

   assign mode    = tec_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
   assign pol_neg = ctrl_r[CTRL_NEG_BIT];
   assign enable  = ctrl_r[CTRL_EN_BIT];

   // ---------------------------------------------------------------
   // trigger line: synchronise, fold polarity, debounce
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         trig_s1_r  <= 1'b0;
         trig_s2_r  <= 1'b0;
         dbn_prev_r <= 1'b0;
      end else begin
         trig_s1_r  <= TRIG_IN;
         trig_s2_r  <= trig_s1_r;
         dbn_prev_r <= dbn_out;
      end
   end

   // active level is high for positive, low for negative polarity
   assign line_act = trig_s2_r ^ pol_neg;

   tec_debounce #(.CW(DBN_W)) u_dbn (
      .clk   (SYS_CLK),
      .rst_b (RST_B),
      .din   (line_act),
      .limit (dbnc_r),
      .dout  (dbn_out)
   );

   assign rise = dbn_out && !dbn_prev_r;
   assign fall = !dbn_out && dbn_prev_r;

   // ---------------------------------------------------------------
   // exposure sequencer
   // ---------------------------------------------------------------
   assign tick    = pre_r == PRE_LAST;
   assign edge_ok = mode == MODE_EDGE || (mode == MODE_EDGE_RJ && !rd_r);

   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      pre_nxt  = pre_r;
      rdst_nxt = 1'b0;
      rd_nxt   = rd_r && !READOUT_DONE;
      case (st_r)
         ST_IDLE: begin
            if (enable) begin
               if (mode == MODE_FREE && !rd_r) begin
                  st_nxt = ST_TIMED;
               end else if (swt_r && mode != MODE_FREE && edge_ok
                            || swt_r && mode == MODE_PULSE) begin
                  st_nxt = ST_TIMED;
               end else if (rise && mode == MODE_PULSE) begin
                  st_nxt = ST_PULSE;
               end else if (rise && edge_ok) begin
                  st_nxt = ST_TIMED;
               end
               if (st_nxt == ST_TIMED) begin
                  cnt_nxt = (expt_r == '0) ? EXP_W'(1) : expt_r;
                  pre_nxt = '0;
               end
            end
         end
         ST_PULSE: begin
            if (fall || mode != MODE_PULSE || !enable) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_TIMED: begin
            pre_nxt = tick ? 6'h00 : pre_r + 6'h01;
            if (tick) begin
               if (cnt_r <= EXP_W'(1)) begin
                  st_nxt = ST_IDLE;
               end else begin
                  cnt_nxt = cnt_r - 1'b1;
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      // end of exposure hands over to image output; set beats clear
      if (st_r != ST_IDLE && st_nxt == ST_IDLE) begin
         rd_nxt   = 1'b1;
         rdst_nxt = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         st_r   <= ST_IDLE;
         cnt_r  <= '0;
         pre_r  <= '0;
         rd_r   <= 1'b0;
         rdst_r <= 1'b0;
         exp_r  <= 1'b0;
         fw_r   <= 1'b1;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         pre_r  <= pre_nxt;
         rd_r   <= rd_nxt;
         rdst_r <= rdst_nxt;
         exp_r  <= st_nxt != ST_IDLE;
         fw_r   <= !(st_nxt != ST_IDLE || rd_nxt);
      end
   end

   assign PRDATA        = rdat_r;
   assign PREADY        = rdy_r;
   assign PSLVERR       = err_r;
   assign EXPOSE        = exp_r;
   assign READOUT_START = rdst_r;
   assign FRAME_WAIT    = fw_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   int unsigned len_r;
   int unsigned want_r;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B || st_r != ST_TIMED) begin
         len_r  <= 1;
         want_r <= CYC_PER_US * int'(cnt_nxt);
      end else begin
         len_r  <= len_r + 1;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   a_pulse_start: assert property (st_r == ST_IDLE && enable && !swt_r
      && mode == MODE_PULSE && rise |=> st_r == ST_PULSE && EXPOSE)
      else $error("pulse exposure did not start");
   a_pulse_hold: assert property (st_r == ST_PULSE && dbn_out && enable
      && mode == MODE_PULSE |=> st_r == ST_PULSE)
      else $error("pulse exposure ended while line active");
   a_pulse_end: assert property (st_r == ST_PULSE && fall
      |=> !EXPOSE && rd_r && READOUT_START)
      else $error("pulse exposure did not end on trailing edge");
   a_timed_len: assert property (st_r == ST_TIMED && st_nxt == ST_IDLE
      |-> len_r == want_r)
      else $error("timed exposure length wrong");
   a_edge_start: assert property (st_r == ST_IDLE && enable && !swt_r
      && mode == MODE_EDGE && rise |=> st_r == ST_TIMED)
      else $error("edge trigger did not start exposure");
   a_reject: assert property (st_r == ST_IDLE && rd_r
      && mode == MODE_EDGE_RJ |=> st_r == ST_IDLE)
      else $error("trigger accepted during image output");
   a_free_run: assert property (st_r == ST_IDLE && enable && !rd_r
      && mode == MODE_FREE |=> st_r == ST_TIMED
      && cnt_r == ($past(expt_r) == '0 ? EXP_W'(1) : $past(expt_r)))
      else $error("free run exposure not preset length");
   a_fw_fall: assert property ($fell(FRAME_WAIT) |-> EXPOSE
      && $rose(EXPOSE))
      else $error("frame wait fell without exposure start");
   a_fw_rise: assert property ($rose(FRAME_WAIT) |-> !EXPOSE
      && $past(rd_r) && !rd_r)
      else $error("frame wait rose before image output end");
   a_sw_trig: assert property (st_r == ST_IDLE && swt_r && enable
      && (mode == MODE_PULSE || mode == MODE_EDGE) |=> st_r == ST_TIMED)
      else $error("software trigger ignored");

   c_pulse_exp: cover property (st_r == ST_PULSE ##[1:50] fall);
   c_timed_exp: cover property (st_r == ST_TIMED && st_nxt == ST_IDLE);
   c_rejected:  cover property (st_r == ST_IDLE && rd_r && rise
      && mode == MODE_EDGE_RJ);
   c_sw_trig:   cover property (swt_r && st_r == ST_IDLE);
endmodule : tec_top
`default_nettype wire

// *** pkg/tec_pkg.sv ***
// constants and types for the trigger exposure control block
`default_nettype none
package tec_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int US_NS         = 1000;
   localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
   localparam logic [5:0] PRE_LAST = 6'(CYC_PER_US - 1);

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  ADR_CTRL   = 8'h00;
   localparam logic [7:0]  ADR_EXPT   = 8'h04;
   localparam logic [7:0]  ADR_DBNC   = 8'h08;
   localparam logic [7:0]  ADR_SWTRG  = 8'h0c;
   localparam logic [7:0]  ADR_STAT   = 8'h10;

   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_NEG_BIT  = 2;
   localparam int CTRL_EN_BIT   = 3;
   // status fields
   localparam int STAT_EXP_BIT  = 0;
   localparam int STAT_RD_BIT   = 1;
   localparam int STAT_FW_BIT   = 2;
   localparam int STAT_LINE_BIT = 3;
   // software trigger field
   localparam int SWTRG_BIT     = 0;

   // reset values
   localparam logic [3:0]  CTRL_RST = 4'h0;
   localparam logic [23:0] EXPT_RST = 24'h006ef4;
   localparam logic [15:0] DBNC_RST = 16'h0064;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FREE    = 2'b00,
      MODE_PULSE   = 2'b01,
      MODE_EDGE    = 2'b10,
      MODE_EDGE_RJ = 2'b11
   } tec_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_PULSE = 2'b01,
      ST_TIMED = 2'b10
   } tec_state_e;
endpackage : tec_pkg
`default_nettype wire

// *** rtl/tec_debounce.sv ***
// debounce filter: output follows input once stable for limit cycles
`default_nettype none
module tec_debounce #(
   parameter int CW = 16
) (
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          din,
   input  wire logic [CW-1:0] limit,
   output logic               dout
);
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          dout_r;
   logic          dout_nxt;

   // limit 0 passes the level straight through
   always_comb begin
      cnt_nxt  = '0;
      dout_nxt = dout_r;
      if (din != dout_r) begin
         if (limit == '0 || cnt_r >= limit - 1'b1) begin
            dout_nxt = din;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_r  <= '0;
         dout_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;

   a_dbn_stable: assert property (@(posedge clk) disable iff (!rst_b)
      ($changed(dout_r) && $past(limit) != '0)
      |-> $past(cnt_r) == $past(limit) - 1'b1 && $past(din) == dout_r)
      else $error("debounce output flipped before input was stable");
endmodule : tec_debounce
`default_nettype wire

// *** test/tec_seq_model.sv ***
// readout sequencer model: answers each readout start with a done pulse
`default_nettype none
module tec_seq_model (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic start,
   input  wire logic slow,
   output logic      done
);
   timeunit 1ns;
   timeprecision 1ps;

   int cnt;

   // ---------------------------------------------------------------
   // image output timing
   // ---------------------------------------------------------------
   // slow answers keep image output busy long enough to test rejection
   always @(posedge clk) begin
      done <= 1'b0;
      if (!rst_b) begin
         cnt <= 0;
      end else if (start) begin
         cnt <= slow ? 60 : 3;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            done <= 1'b1;
         end
      end
   end
endmodule : tec_seq_model
`default_nettype wire

// *** test/test_tec_top.sv ***
// self-checking bench for the trigger exposure control block
`default_nettype none
module test_tec_top import tec_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int EXP_CYC = 2 * CYC_PER_US;
   logic        clk     = 1'b0;
   logic        rst_b   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic        trig    = 1'b0;
   logic        slow    = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        expose;
   logic        rd_start;
   logic        rd_done;
   logic        fwait;
   int          n_mismatch   = 0;
   int          total_checks = 0;

   always #10 clk = ~clk;

   tec_top i_tec_top (
      .SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TRIG_IN(trig),
      .READOUT_DONE(rd_done), .EXPOSE(expose),
      .READOUT_START(rd_start), .FRAME_WAIT(fwait)
   );

   tec_seq_model i_tec_seq_model (
      .clk(clk), .rst_b(rst_b), .start(rd_start), .slow(slow),
      .done(rd_done)
   );

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic hang;
      n_mismatch++;
      conclude();
   endtask : hang

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // active level held for w cycles, then the line returns to its idle level
   task automatic pulse(input logic neg, input int w);
      trig <= !neg;
      repeat (w) @(posedge clk);
      trig <= neg;
   endtask : pulse

   task automatic expo(output int len);
      int n;
      n = 0;
      while (expose !== 1'b1) begin
         @(posedge clk);
         if (++n > 3000) hang();
      end
      len = 0;
      while (expose === 1'b1) begin
         @(posedge clk);
         if (++len > 3000) hang();
      end
   endtask : expo

   task automatic watch(input int cyc, output int hits);
      hits = 0;
      repeat (cyc) begin
         @(posedge clk);
         if (expose === 1'b1) hits++;
      end
   endtask : watch

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic        err;
      logic [3:0]  c;
      int          len;
      int          w;
      int          hits;
      void'($urandom(5));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      apb(1'b0, ADR_CTRL, 32'h0, rd, err);
      chk("ctrl reset", rd, 32'(CTRL_RST));
      chk("mapped err", 32'(err), 32'h0);
      apb(1'b0, ADR_EXPT, 32'h0, rd, err);
      chk("expt reset", rd, 32'(EXPT_RST));
      apb(1'b0, ADR_DBNC, 32'h0, rd, err);
      chk("dbnc reset", rd, 32'(DBNC_RST));
      apb(1'b0, ADR_STAT, 32'h0, rd, err);
      chk("stat idle", rd, 32'h1 << STAT_FW_BIT);
      apb(1'b0, 8'h14, 32'h0, rd, err);
      chk("unmapped err", 32'(err), 32'h1);
      apb(1'b1, ADR_EXPT, 32'h2, rd, err);
      apb(1'b1, ADR_DBNC, 32'h4, rd, err);
      apb(1'b0, ADR_EXPT, 32'h0, rd, err);
      chk("expt rw", rd, 32'h2);
      $display("test registers done");
      // pulse, edge and rejecting modes in both polarities
      for (int m = 1; m < 4; m++) begin
         for (int ng = 0; ng < 2; ng++) begin
            c = {1'b1, 1'(ng), 2'(m)};
            // new polarity while disabled, so the line settles first
            apb(1'b1, ADR_CTRL, 32'(c) & 32'h7, rd, err);
            trig <= 1'(ng);
            repeat (20) @(posedge clk);
            apb(1'b1, ADR_CTRL, 32'(c), rd, err);
            w = 10 + int'($urandom % 40);
            fork
               pulse(1'(ng), w);
               expo(len);
            join
            if (m == 1) begin
               chk("pulse len", 32'(len >= w - 1 && len <= w + 1),
                   32'h1);
            end else begin
               chk("edge len", 32'(len), 32'(EXP_CYC));
            end
            chk("fwait low", 32'(fwait), 32'h0);
            chk("rd start", 32'(rd_start), 32'h1);
            repeat (10) @(posedge clk);
            chk("fwait high", 32'(fwait), 32'h1);
         end
      end
      $display("test trigger modes done");
      // short pulse must be filtered
      apb(1'b1, ADR_CTRL, 32'h1, rd, err);
      trig <= 1'b0;
      repeat (20) @(posedge clk);
      apb(1'b1, ADR_CTRL, 32'h9, rd, err);
      pulse(1'b0, 2);
      watch(30, hits);
      chk("short pulse", 32'(hits), 32'h0);
      $display("test debounce done");
      // trigger during slow image output: mode 3 drops, mode 2 takes
      slow <= 1'b1;
      for (int m = 3; m > 1; m--) begin
         apb(1'b1, ADR_CTRL, 32'(8 + m), rd, err);
         fork
            pulse(1'b0, 10);
            expo(len);
         join
         repeat (5) @(posedge clk);
         fork
            pulse(1'b0, 10);
            watch(40, hits);
         join
         chk("image out trig", 32'(hits > 0), 32'(m == 2));
         repeat (250) @(posedge clk);
      end
      slow <= 1'b0;
      $display("test overlap done");
      // software trigger gives a preset exposure
      apb(1'b1, ADR_CTRL, 32'h9, rd, err);
      apb(1'b1, ADR_SWTRG, 32'h1, rd, err);
      expo(len);
      chk("sw trig len", 32'(len), 32'(EXP_CYC));
      repeat (10) @(posedge clk);
      $display("test software trigger done");
      // free running: every exposure has the same length
      apb(1'b1, ADR_CTRL, 32'h8, rd, err);
      repeat (2) begin
         expo(len);
         chk("free len", 32'(len), 32'(EXP_CYC));
      end
      apb(1'b1, ADR_CTRL, 32'h0, rd, err);
      $display("test free run done");
      conclude();
   end
endmodule : test_tec_top
`default_nettype wire
